// [aip_defines.svh]
// constants for the analog input processing link and its two ends
//
// Overview of operation
// - channel samples are eleven bits plus sign
// - scan cycle set by line frequency
// - fixed cycle length, conversion synchronous to line
// - line frequency 50, 60, 16.7 Hz; default 50
// - one line frequency setting for all channels
// - inputs inside zero range forced to zero
// - smoothing factor 2 to 128, default off
// - four reporting modes, integrated threshold default
// - changes sent as events, not every sample
// - two internal channels give zero calibration
// - range 2.5, 5, 10 or 20 mA
// - bipolar, unipolar or live zero; bipolar default
// - live zero scaled 0..100 or -100..100 percent
// - unit loads all parameters before measurement starts; code leaves order to software
// - self-test faults reported and shown on indicator
// - indicator set after two minutes without poll
`ifndef AIP_DEFINES_SVH
`define AIP_DEFINES_SVH

`define AIP_CLK_HZ 20000000
`define AIP_CYC_PER_MS (`AIP_CLK_HZ / 1000)
`define AIP_CONV_60HZ_MS 50
`define AIP_CONV_50HZ_MS 60
`define AIP_CONV_16HZ_MS 200
`define AIP_POLL_TMO_S 120
`define AIP_POLL_PERIOD_MS 1000

`define AIP_NCH 6
`define AIP_SLOT_CAL_A 3'h6
`define AIP_SLOT_CAL_B 3'h7
`define AIP_CH_GLOBAL 3'h7
`define AIP_G_LFREQ 3'h0
`define AIP_G_START 3'h1

`define AIP_LZ_4MA 18'h0019a
`define AIP_LZ_12MA 18'h004cd
`define AIP_ZERO_DEF 7'h05
`define AIP_ZERO_MIN 7'h02
`define AIP_ZERO_MAX 7'h66
`define AIP_CAL_LIMIT 13'h0100
`define AIP_THR_DEF 12'h014
`define AIP_PER_DEF 8'h0a

`define AIP_A_CTRL 8'h00
`define AIP_A_CFG 8'h04
`define AIP_A_STAT 8'h08
`define AIP_A_EVT 8'h0c
`define AIP_A_IRQ_ST 8'h10
`define AIP_A_IRQ_CLR 8'h14
`define AIP_A_IRQ_EN 8'h18
`define AIP_IRQ_EVT 0
`define AIP_IRQ_FLT 1
`define AIP_IRQ_REJ 2

`endif

// [aip_pkg.sv]
// types shared by the analog input device and its communication unit
package aip_pkg;
    typedef enum logic [1:0] {
        AIP_LF_50 = 2'b00,
        AIP_LF_60 = 2'b01,
        AIP_LF_16 = 2'b10
    } aip_lf_t;
    typedef enum logic [1:0] {
        AIP_RNG_2M5 = 2'b00,
        AIP_RNG_5M = 2'b01,
        AIP_RNG_10M = 2'b10,
        AIP_RNG_20M = 2'b11
    } aip_rng_t;
    typedef enum logic [1:0] {
        AIP_SIG_BIP = 2'b00,
        AIP_SIG_UNI = 2'b01,
        AIP_SIG_LZ = 2'b10
    } aip_sig_t;
    typedef enum logic [1:0] {
        AIP_MODE_INT = 2'b00,
        AIP_MODE_ABS = 2'b01,
        AIP_MODE_PER = 2'b10,
        AIP_MODE_INTPER = 2'b11
    } aip_mode_t;
    typedef enum logic [2:0] {
        AIP_P_RANGE = 3'b000,
        AIP_P_SIGTYPE = 3'b001,
        AIP_P_LZADJ = 3'b010,
        AIP_P_ZERO = 3'b011,
        AIP_P_SMOOTH = 3'b100,
        AIP_P_MODE = 3'b101,
        AIP_P_THRESH = 3'b110,
        AIP_P_PERIOD = 3'b111
    } aip_par_t;
    typedef enum logic {
        AIP_CU_IDLE = 1'b0,
        AIP_CU_BUSY = 1'b1
    } aip_cu_st_t;
endpackage

// [aip_io_if.sv]
// field I/O link between the analog input device and the communication unit
`timescale 1ns/10ps
`default_nettype none
interface aip_io_if;
    logic cfg_valid;
    logic cfg_ready;
    logic [2:0] cfg_ch;
    logic [2:0] cfg_sel;
    logic [15:0] cfg_data;
    logic poll;
    logic evt_valid;
    logic evt_ready;
    logic [2:0] evt_ch;
    logic [11:0] evt_value;
    logic [4:0] fault;
    modport dev (
        input cfg_valid, cfg_ch, cfg_sel, cfg_data, poll, evt_ready,
        output cfg_ready, evt_valid, evt_ch, evt_value, fault
    );
    modport cu (
        output cfg_valid, cfg_ch, cfg_sel, cfg_data, poll, evt_ready,
        input cfg_ready, evt_valid, evt_ch, evt_value, fault
    );
endinterface
`default_nettype wire

// [aip_dev.sv]
// analog input device: scan timing, calibration, per-channel processing
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "aip_defines.svh"
module aip_dev #(
    parameter int unsigned CONV60_CYC = `AIP_CONV_60HZ_MS * `AIP_CYC_PER_MS,
    parameter int unsigned CONV50_CYC = `AIP_CONV_50HZ_MS * `AIP_CYC_PER_MS,
    parameter int unsigned CONV16_CYC = `AIP_CONV_16HZ_MS * `AIP_CYC_PER_MS,
    parameter int unsigned POLL_TMO_CYC =
        32'(64'd`AIP_POLL_TMO_S * 64'd`AIP_CLK_HZ)
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // link to the communication unit
    aip_io_if.dev io,
    // converter
    output logic conv_start_o,
    output logic [2:0] conv_ch_o,
    input wire logic adc_valid_i,
    input wire logic signed [12:0] adc_data_i,
    input wire logic adc_err_i,
    // indicator
    output logic fault_led_o
);
    function automatic logic signed [11:0] sat12(input logic signed [17:0] x);
        if (x[17:11] != {7{x[17]}})
            sat12 = x[17] ? 12'sh801 : 12'sh7ff;
        else if (x[11:0] == 12'h800)
            sat12 = 12'sh801;
        else
            sat12 = x[11:0];
    endfunction

    function automatic logic [12:0] abs13(input logic signed [12:0] x);
        abs13 = x[12] ? 13'(-x) : x;
    endfunction

    // global state
    aip_pkg::aip_lf_t lf_q;
    logic run_q, first_q, got_q, tout_q, cal_bad_q;
    logic [31:0] tmr_q, wd_q;
    logic err_s1_q, err_s2_q, err_s3_q, err_q;
    logic signed [12:0] cal_a_q, cal_b_q;
    // per-channel parameters and state
    logic [1:0] rng_q [`AIP_NCH];
    logic [1:0] sig_q [`AIP_NCH];
    logic lza_q [`AIP_NCH];
    logic [6:0] zb_q [`AIP_NCH];
    logic [2:0] smk_q [`AIP_NCH];
    logic [1:0] mode_q [`AIP_NCH];
    logic [11:0] thr_q [`AIP_NCH];
    logic [7:0] per_q [`AIP_NCH];
    logic signed [19:0] acc_q [`AIP_NCH];
    logic signed [11:0] last_q [`AIP_NCH];
    logic [15:0] integ_q [`AIP_NCH];
    logic [7:0] pcnt_q [`AIP_NCH];
    // event output
    logic evt_valid_q;
    logic [2:0] evt_ch_q;
    logic [11:0] evt_val_q;

    // scan timing: eight equal slots, six inputs then two zero references
    wire [31:0] slot_len = (lf_q == aip_pkg::AIP_LF_60) ? CONV60_CYC :
        (lf_q == aip_pkg::AIP_LF_16) ? CONV16_CYC : CONV50_CYC;
    wire slot_end = run_q && (tmr_q == 32'h0);
    wire [2:0] nxt_slot = first_q ? 3'h0 : 3'(conv_ch_o + 3'h1);
    wire is_meas = (conv_ch_o < 3'(`AIP_NCH));
    wire [2:0] ci = is_meas ? conv_ch_o : 3'h0;
    wire sample = adc_valid_i && run_q && !first_q;

    // zero calibration from the two reference slots
    wire signed [13:0] cal_sum = 14'(cal_a_q) + 14'(cal_b_q);
    wire signed [12:0] offset = 13'(cal_sum >>> 1);
    wire signed [13:0] corr = 14'(adc_data_i) - 14'(offset);
    wire signed [17:0] corr18 = 18'(corr);

    // range scaling: full scale of each range maps to 2048 steps
    wire [1:0] rsh = 2'(2'd3 - rng_q[ci]);
    wire signed [11:0] scl = sat12((corr18 <<< rsh) >>> 1);
    wire signed [17:0] scl18 = 18'(scl);
    wire signed [17:0] lz_off = lza_q[ci] ? scl18 - $signed(`AIP_LZ_12MA) :
        scl18 - $signed(`AIP_LZ_4MA);
    wire signed [17:0] lz_x = lza_q[ci] ? (lz_off <<< 1) + (lz_off >>> 1) :
        lz_off + (lz_off >>> 2);
    wire signed [11:0] typed = (sig_q[ci] == aip_pkg::AIP_SIG_LZ) ?
        sat12(lz_x) : ((sig_q[ci] == aip_pkg::AIP_SIG_UNI) && scl[11]) ?
        12'sh000 : scl;

    // zero supervision
    wire [12:0] typ_abs = abs13(13'(typed));
    wire signed [11:0] zv = (typ_abs <= 13'(zb_q[ci])) ?
        12'sh000 : typed;

    // recursive average, one k-th of the error per sample
    // the concatenation is unsigned, so restore the sign before widening
    wire signed [20:0] s_diff = 21'($signed({zv, 8'h00})) - 21'(acc_q[ci]);
    wire signed [20:0] s_step = s_diff >>> smk_q[ci];
    wire signed [19:0] s_next = 20'(21'(acc_q[ci]) + s_step);
    wire signed [11:0] sm = s_next[19:8];

    // reporting decisions
    wire [12:0] dev_abs = abs13(13'(sm) - 13'(last_q[ci]));
    wire [16:0] integ_w = 17'(integ_q[ci]) + 17'(dev_abs);
    wire [15:0] integ_s = integ_w[16] ? 16'hffff : integ_w[15:0];
    wire int_hit = integ_s >= 16'(thr_q[ci]);
    wire abs_hit = dev_abs >= 13'(thr_q[ci]);
    wire per_hit = (pcnt_q[ci] == 8'h00);
    wire hit = (mode_q[ci] == aip_pkg::AIP_MODE_INT) ? int_hit :
        (mode_q[ci] == aip_pkg::AIP_MODE_ABS) ? abs_hit :
        (mode_q[ci] == aip_pkg::AIP_MODE_PER) ? per_hit :
        (int_hit || per_hit);
    // a taken event frees the slot in the same cycle, so a new one wins
    wire evt_free = !evt_valid_q || io.evt_ready;
    wire meas_ok = sample && is_meas;
    wire send = meas_ok && hit && evt_free;
    wire [7:0] per_ld = (per_q[ci] == 8'h00) ? 8'h00 : 8'(per_q[ci] - 8'h01);

    // configuration writes, taken on every valid cycle
    wire cfg_glb = io.cfg_valid && (io.cfg_ch == `AIP_CH_GLOBAL);
    wire cfg_chn = io.cfg_valid && (io.cfg_ch < 3'(`AIP_NCH));
    wire [6:0] zb_in = (io.cfg_data[6:0] < `AIP_ZERO_MIN) ? `AIP_ZERO_MIN :
        (io.cfg_data[6:0] > `AIP_ZERO_MAX) ? `AIP_ZERO_MAX :
        io.cfg_data[6:0];

    assign io.cfg_ready = 1'b1;
    assign io.evt_valid = evt_valid_q;
    assign io.evt_ch = evt_ch_q;
    assign io.evt_value = evt_val_q;
    assign io.fault = {(wd_q == POLL_TMO_CYC), cal_bad_q, tout_q, err_q,
        !run_q};
    assign fault_led_o = |io.fault;

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            lf_q <= aip_pkg::AIP_LF_50;
            run_q <= 1'b0;
        end
        else if (cfg_glb && (io.cfg_sel == `AIP_G_LFREQ) &&
            (io.cfg_data[1:0] != 2'b11))
            lf_q <= aip_pkg::aip_lf_t'(io.cfg_data[1:0]);
        else if (cfg_glb && (io.cfg_sel == `AIP_G_START))
            run_q <= io.cfg_data[0];
    end

    // conversion is released only at slot boundaries; each slot is a whole
    // number of line periods at 50 and 60 Hz, so line hum integrates out
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            tmr_q <= 32'h0;
            first_q <= 1'b1;
            got_q <= 1'b0;
            tout_q <= 1'b0;
            conv_start_o <= 1'b0;
            conv_ch_o <= 3'h0;
        end
        else
        begin
            conv_start_o <= slot_end;
            if (!run_q)
            begin
                tmr_q <= 32'h0;
                first_q <= 1'b1;
                got_q <= 1'b0;
            end
            else if (slot_end)
            begin
                tmr_q <= slot_len - 32'h1;
                conv_ch_o <= nxt_slot;
                first_q <= 1'b0;
                got_q <= 1'b0;
                if (!first_q)
                    tout_q <= !(got_q || adc_valid_i);
            end
            else
            begin
                tmr_q <= tmr_q - 32'h1;
                if (adc_valid_i)
                    got_q <= 1'b1;
            end
        end
    end

    // converter error pin and poll supervision
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            {err_s1_q, err_s2_q, err_s3_q, err_q} <= 4'h0;
            wd_q <= 32'h0;
        end
        else
        begin
            err_s1_q <= adc_err_i;
            err_s2_q <= err_s1_q;
            err_s3_q <= err_s2_q;
            if (err_s2_q == err_s3_q)
                err_q <= err_s3_q;
            if (io.poll)
                wd_q <= 32'h0;
            else if (wd_q != POLL_TMO_CYC)
                wd_q <= wd_q + 32'h1;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            cal_a_q <= 13'sh0000;
            cal_b_q <= 13'sh0000;
            cal_bad_q <= 1'b0;
        end
        else if (sample && !is_meas)
        begin
            if (conv_ch_o == `AIP_SLOT_CAL_A)
                cal_a_q <= adc_data_i;
            if (conv_ch_o == `AIP_SLOT_CAL_B)
                cal_b_q <= adc_data_i;
            cal_bad_q <= abs13(adc_data_i) > `AIP_CAL_LIMIT;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            for (int i = 0; i < `AIP_NCH; i++)
            begin
                rng_q[i] <= aip_pkg::AIP_RNG_20M;
                sig_q[i] <= aip_pkg::AIP_SIG_BIP;
                lza_q[i] <= 1'b0;
                zb_q[i] <= `AIP_ZERO_DEF;
                smk_q[i] <= 3'h0;
                mode_q[i] <= aip_pkg::AIP_MODE_INT;
                thr_q[i] <= `AIP_THR_DEF;
                per_q[i] <= `AIP_PER_DEF;
            end
        end
        else if (cfg_chn)
        begin
            case (aip_pkg::aip_par_t'(io.cfg_sel))
                aip_pkg::AIP_P_RANGE: rng_q[io.cfg_ch] <= io.cfg_data[1:0];
                aip_pkg::AIP_P_SIGTYPE:
                    if (io.cfg_data[1:0] != 2'b11)
                        sig_q[io.cfg_ch] <= io.cfg_data[1:0];
                aip_pkg::AIP_P_LZADJ: lza_q[io.cfg_ch] <= io.cfg_data[0];
                aip_pkg::AIP_P_ZERO: zb_q[io.cfg_ch] <= zb_in;
                aip_pkg::AIP_P_SMOOTH: smk_q[io.cfg_ch] <= io.cfg_data[2:0];
                aip_pkg::AIP_P_MODE: mode_q[io.cfg_ch] <= io.cfg_data[1:0];
                aip_pkg::AIP_P_THRESH: thr_q[io.cfg_ch] <= io.cfg_data[11:0];
                aip_pkg::AIP_P_PERIOD: per_q[io.cfg_ch] <= io.cfg_data[7:0];
                default: ;
            endcase
        end
    end

    // channel state; a blocked event keeps integrating and retries next scan
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            for (int i = 0; i < `AIP_NCH; i++)
            begin
                acc_q[i] <= 20'sh00000;
                last_q[i] <= 12'sh000;
                integ_q[i] <= 16'h0000;
                pcnt_q[i] <= 8'h00;
            end
        end
        else if (meas_ok)
        begin
            acc_q[ci] <= s_next;
            if (send)
            begin
                last_q[ci] <= sm;
                integ_q[ci] <= 16'h0000;
                pcnt_q[ci] <= per_ld;
            end
            else
            begin
                integ_q[ci] <= integ_s;
                if (!per_hit)
                    pcnt_q[ci] <= 8'(pcnt_q[ci] - 8'h01);
            end
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            evt_valid_q <= 1'b0;
            evt_ch_q <= 3'h0;
            evt_val_q <= 12'h000;
        end
        else if (send)
        begin
            evt_valid_q <= 1'b1;
            evt_ch_q <= conv_ch_o;
            evt_val_q <= sm;
        end
        else if (io.evt_ready)
            evt_valid_q <= 1'b0;
    end
endmodule
`default_nettype wire

// [aip_cu.sv]
// communication unit end: APB registers, parameter download, polling, events
`timescale 1ns/10ps
`default_nettype none
`include "aip_defines.svh"
module aip_cu #(
    parameter int unsigned POLL_CYC = `AIP_POLL_PERIOD_MS * `AIP_CYC_PER_MS
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic irq_o,
    // link to the device
    aip_io_if.cu io
);
    aip_pkg::aip_cu_st_t st_q;
    logic poll_en_q, poll_q, evt_pend_q;
    logic [31:0] pcnt_q;
    logic [2:0] ch_q, sel_q, evch_q;
    logic [15:0] data_q;
    logic [11:0] evval_q;
    logic [4:0] flt_q;
    logic [2:0] ist_q, ien_q;

    wire acc = psel_i && penable_i;
    wire wr = acc && pwrite_i;
    wire rd = acc && !pwrite_i;
    wire a_ctrl = (paddr_i == `AIP_A_CTRL);
    wire a_cfg = (paddr_i == `AIP_A_CFG);
    wire a_stat = (paddr_i == `AIP_A_STAT);
    wire a_evt = (paddr_i == `AIP_A_EVT);
    wire a_ist = (paddr_i == `AIP_A_IRQ_ST);
    wire a_iclr = (paddr_i == `AIP_A_IRQ_CLR);
    wire a_ien = (paddr_i == `AIP_A_IRQ_EN);
    wire mapped = a_ctrl || a_cfg || a_stat || a_evt || a_ist || a_iclr ||
        a_ien;
    wire [31:0] rmux = a_ctrl ? {31'h0, poll_en_q} :
        a_stat ? {24'h0, !io.fault[0], flt_q, evt_pend_q,
            (st_q == aip_pkg::AIP_CU_BUSY)} :
        a_evt ? {13'h0, evch_q, 4'h0, evval_q} :
        a_ist ? {29'h0, ist_q} :
        a_ien ? {29'h0, ien_q} : 32'h0;

    // line frequency only as one module-wide setting; ranges limited
    wire [2:0] w_ch = pwdata_i[18:16];
    wire [2:0] w_sel = pwdata_i[22:20];
    wire glb_ok = (w_ch == `AIP_CH_GLOBAL) && ((w_sel == `AIP_G_START) ||
        ((w_sel == `AIP_G_LFREQ) && (pwdata_i[1:0] != 2'b11)));
    wire chn_ok = (w_ch < 3'(`AIP_NCH)) &&
        ((w_sel != aip_pkg::AIP_P_RANGE) || (pwdata_i[15:2] == 14'h0));
    wire cfg_wr = wr && a_cfg;
    // start is only legal as the last word of a download, so software
    // orders it; the port keeps word order
    wire cfg_take = cfg_wr && (st_q == aip_pkg::AIP_CU_IDLE) &&
        (glb_ok || chn_ok);
    wire cfg_rej = cfg_wr && !cfg_take;
    wire evt_take = io.evt_valid && !evt_pend_q;
    wire [2:0] iset = {cfg_rej, |(io.fault & ~flt_q), evt_take};
    wire [2:0] iclr = (wr && a_iclr) ? pwdata_i[2:0] : 3'h0;

    assign pready_o = acc;
    assign pslverr_o = acc && !mapped;
    assign irq_o = |(ist_q & ien_q);
    assign io.cfg_valid = (st_q == aip_pkg::AIP_CU_BUSY);
    assign io.cfg_ch = ch_q;
    assign io.cfg_sel = sel_q;
    assign io.cfg_data = data_q;
    assign io.poll = poll_q;
    assign io.evt_ready = !evt_pend_q;

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            prdata_o <= 32'h0;
        else if (psel_i && !penable_i)
            prdata_o <= rmux;
    end

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_q <= aip_pkg::AIP_CU_IDLE;
            ch_q <= 3'h0;
            sel_q <= 3'h0;
            data_q <= 16'h0;
        end
        else
        begin
            case (st_q)
                aip_pkg::AIP_CU_IDLE:
                    if (cfg_take)
                    begin
                        st_q <= aip_pkg::AIP_CU_BUSY;
                        ch_q <= w_ch;
                        sel_q <= w_sel;
                        data_q <= pwdata_i[15:0];
                    end
                aip_pkg::AIP_CU_BUSY:
                    if (io.cfg_ready)
                        st_q <= aip_pkg::AIP_CU_IDLE;
                default: st_q <= aip_pkg::AIP_CU_IDLE;
            endcase
        end
    end

    // periodic poll keeps the device supervision quiet
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            poll_en_q <= 1'b0;
            poll_q <= 1'b0;
            pcnt_q <= 32'h0;
        end
        else
        begin
            if (wr && a_ctrl)
                poll_en_q <= pwdata_i[0];
            poll_q <= poll_en_q && (pcnt_q == 32'h0);
            if (!poll_en_q || (pcnt_q == 32'h0))
                pcnt_q <= POLL_CYC - 32'h1;
            else
                pcnt_q <= pcnt_q - 32'h1;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            evt_pend_q <= 1'b0;
            evch_q <= 3'h0;
            evval_q <= 12'h0;
            flt_q <= 5'h0;
            ist_q <= 3'h0;
            ien_q <= 3'h0;
        end
        else
        begin
            if (evt_take)
            begin
                evt_pend_q <= 1'b1;
                evch_q <= io.evt_ch;
                evval_q <= io.evt_value;
            end
            else if (rd && a_evt)
                evt_pend_q <= 1'b0;
            flt_q <= io.fault;
            ist_q <= (ist_q & ~iclr) | iset;
            if (wr && a_ien)
                ien_q <= pwdata_i[2:0];
        end
    end
endmodule
`default_nettype wire

// [aip_link_sva.sv]
// checker for the link between device and communication unit
`timescale 1ns/10ps
`default_nettype none
module aip_link_sva #(
    parameter int unsigned POLL_TMO_CYC = 2000
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // link signals
    input wire logic cfg_valid,
    input wire logic [2:0] cfg_ch,
    input wire logic [2:0] cfg_sel,
    input wire logic [15:0] cfg_data,
    input wire logic poll,
    input wire logic evt_valid,
    input wire logic evt_ready,
    input wire logic [2:0] evt_ch,
    input wire logic [11:0] evt_value,
    input wire logic [4:0] fault
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    logic [31:0] idle_q;
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
            idle_q <= 32'h0;
        else if (poll)
            idle_q <= 32'h0;
        else
            idle_q <= idle_q + 32'h1;
    end
    evt_hold_a: assert property (
        evt_valid && !evt_ready |=> evt_valid && $stable({evt_ch, evt_value}))
        else $error("event word changed before taken");
    evt_chan_a: assert property (evt_valid |-> evt_ch < 3'h6)
        else $error("event from a reference slot");
    evt_span_a: assert property (
        evt_valid |-> $signed(evt_value) >= -12'sd2047)
        else $error("event value beyond full scale");
    evt_take_a: assert property (evt_valid && evt_ready |=> !evt_ready)
        else $error("unit ready again before event read");
    cfg_space_a: assert property (cfg_valid |=> !cfg_valid)
        else $error("config words closer than two cycles");
    start_run_a: assert property (
        cfg_valid && cfg_ch == 3'h7 && cfg_sel == 3'h1 && cfg_data == 16'h1
        |=> !fault[0]) else $error("init fault kept after start");
    poll_clear_a: assert property (poll |=> !fault[4])
        else $error("poll fault kept after poll");
    poll_tmo_a: assert property ($rose(fault[4]) |->
        idle_q + 3 >= POLL_TMO_CYC && idle_q <= POLL_TMO_CYC + 3)
        else $error("poll fault at wrong time");
    reset_flt_a: assert property ($fell(reset_i) |-> fault == 5'h01)
        else $error("wrong fault state after reset");
endmodule
`default_nettype wire

// [analog_input_processing_test.sv]
// testbench: device and unit joined, driven over apb and converter pins
`timescale 1ns/10ps
`default_nettype none
module analog_input_processing_test;
    logic mclk, reset, psel, penable, pwrite, adc_valid, adc_err, slverr;
    logic conv_start, pready, irq, led;
    logic [7:0] paddr;
    logic [2:0] conv_ch;
    logic [31:0] pwdata, prdata, rd, seed, r;
    logic signed [12:0] adc_data;
    logic signed [12:0] val [8];
    logic [7:0] seen;
    int err_total, n_compared, n, k;
    int lfc[3] = '{1, 2, 0};
    int lfs[3] = '{40, 160, 48};
    aip_io_if aip_io_if_i ();
    aip_dev #(.CONV60_CYC(40), .CONV50_CYC(48), .CONV16_CYC(160),
        .POLL_TMO_CYC(2000)) aip_dev_i (.mclk_i(mclk), .reset_i(reset),
        .io(aip_io_if_i.dev), .conv_start_o(conv_start), .conv_ch_o(conv_ch),
        .adc_valid_i(adc_valid), .adc_data_i(adc_data), .adc_err_i(adc_err),
        .fault_led_o(led));
    aip_cu #(.POLL_CYC(200)) aip_cu_i (.mclk_i(mclk), .reset_i(reset),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(slverr), .irq_o(irq),
        .io(aip_io_if_i.cu));
    aip_link_sva aip_link_sva_i (.mclk_i(mclk),
        .reset_i(reset), .cfg_valid(aip_io_if_i.cfg_valid),
        .cfg_ch(aip_io_if_i.cfg_ch), .cfg_sel(aip_io_if_i.cfg_sel),
        .cfg_data(aip_io_if_i.cfg_data), .poll(aip_io_if_i.poll),
        .evt_valid(aip_io_if_i.evt_valid), .evt_ready(aip_io_if_i.evt_ready),
        .evt_ch(aip_io_if_i.evt_ch), .evt_value(aip_io_if_i.evt_value),
        .fault(aip_io_if_i.fault));
    always #25 mclk = ~mclk;
    // converter answers one cycle after each start pulse
    always @(posedge mclk)
    begin
        adc_valid <= conv_start;
        adc_data <= val[conv_ch];
    end
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        @(posedge mclk);
        while (pready !== 1'b1 && k < 100)
        begin
            @(posedge mclk);
            k++;
        end
        if (k >= 100)
            err_total++;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // config word is taken one cycle after the access edge
    task cfg(input logic [2:0] ch, input logic [2:0] sel, input logic [15:0] d);
        apb(1'b1, 8'h04, {9'h0, sel, 1'b0, ch, d});
        repeat (4) @(posedge mclk);
    endtask
    task gap(output int g);
        logic [2:0] c;
        g = 0;
        while (conv_start !== 1'b1 && g < 400)
        begin
            @(posedge mclk);
            g++;
        end
        if (g >= 400)
            err_total++;
        c = conv_ch;
        g = 0;
        do
        begin
            @(posedge mclk);
            g++;
        end
        while (conv_start !== 1'b1 && g < 400);
        if (g >= 400)
            err_total++;
        check(conv_ch, 3'(c + 3'h1));
    endtask
    task wait_irq;
        n = 0;
        while (irq !== 1'b1 && n < 3000)
        begin
            @(posedge mclk);
            n++;
        end
        if (n >= 3000)
            err_total++;
        apb(1'b1, 8'h14, 32'h1);
        apb(1'b0, 8'h0c, 32'h0);
    endtask
    // expected event word, references at 16 codes, input 0 on 10 mA range
    function automatic logic [31:0] exp_evt(input logic [2:0] ch);
        int x;
        x = ((int'(val[ch]) - 16) * (ch == 3'h0 ? 2 : 1)) >>> 1;
        x = x > 2047 ? 2047 : (x < -2047 ? -2047 : x);
        x = (x <= 5 && x >= -5) ? 0 : x;
        return {13'h0, ch, 4'h0, x[11:0]};
    endfunction
    initial
    begin
        {mclk, psel, penable, pwrite, adc_err, paddr} = '0;
        {pwdata, seen, err_total, n_compared} = '0;
        seed = 32'h8b41;
        reset = 1'b1;
        val = '{13'sh0fff, -13'sh1000, 0, 0, 0, 13'sd11, 13'sd16, 13'sd16};
        for (int i = 2; i < 5; i++)
        begin
            r = $random(seed);
            val[i] = r[31] ? -(13'(r[10:0]) + 13'd64) : 13'(r[10:0]) + 13'd64;
        end
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        apb(1'b0, 8'h08, 32'h0);
        check(rd, 32'h04);
        apb(1'b0, 8'h20, 32'h0);
        check(rd, 32'h0);
        check(slverr, 1'b1);
        cfg(3'h0, 3'h0, 16'h2);
        cfg(3'h7, 3'h1, 16'h1);
        gap(n);
        check(n, 48);
        for (int i = 0; i < 3; i++)
        begin
            cfg(3'h7, 3'h0, 16'(lfc[i]));
            gap(n);
            gap(n);
            check(n, lfs[i]);
        end
        apb(1'b0, 8'h10, 32'h0);
        check({rd[0], irq}, 2'b10);
        apb(1'b1, 8'h18, 32'h1);
        repeat (5)
        begin
            wait_irq();
            check(rd, exp_evt(rd[18:16]));
            check(irq, 1'b0);
            seen[rd[18:16]] = 1'b1;
        end
        check(seen, 8'h1f);
        repeat (400) @(posedge mclk);
        apb(1'b0, 8'h08, 32'h0);
        check(rd[1], 1'b0);
        val[5] = 13'sd28;
        wait_irq();
        check(rd, {13'h0, 3'h5, 16'h0006});
        check(n > 1100, 1'b1);
        check({aip_io_if_i.fault[4], led}, 2'b11);
        apb(1'b1, 8'h00, 32'h1);
        repeat (300) @(posedge mclk);
        check({aip_io_if_i.fault[4], led}, 2'b00);
        adc_err <= 1'b1;
        repeat (10) @(posedge mclk);
        check({aip_io_if_i.fault[1], led}, 2'b11);
        test_done();
    end
    initial
    begin
        repeat (40000) @(posedge mclk);
        err_total++;
        test_done();
    end
endmodule
`default_nettype wire
